/* logic/rxfq_dma.sv */
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Descriptor dword 0 holds buffer address.
// R2: Dword 1 low half holds next index.
// R3: Dword 1 bits 16-28 hold byte count.
// R4: Buffer status codes first, middle, last.
// R5: Dword 2 low byte holds channel minus one.
// R6: Dword 2 upper bits hold 16-cycle timestamp.
// R7: Descriptor dword 3 is never written.
// R8: Host leaves dword 3 for transmit side.
// R9: Word layout independent of byte order.
// R10: Free entry: address, then 16-bit index.
// R11: Free index is offset from descriptor base.
// R12: Separate large and small free queues.
// R13: Single size: small start equals end.
// R14: Device owns read, host write pointers.
// R15: Queue empty when pointers are equal.
// R16: Host keeps one entry always unused.
// R17: Entry address is base plus pointer times eight.
// R18: No fetch until receive DMA enabled.
// R19: Read pointer advances one entry per fetch.
// R20: Read pointer wraps to zero at limit.
// R21: Host writes queue base as two halves.
// R22: Descriptors are quad-dword aligned, 65536 max.
// R23: Host writes descriptor base as two halves.
// R24: Empty queue flags error, pointer unchanged.
// R25: Descriptor address is base plus index times sixteen.
module rxfq_dma
	import rxfq_pkg::*;
(
	input  wire logic        hclk,        // Bus clock, 200 MHz.
	input  wire logic        hresetn,     // Asynchronous reset, active low.
	input  wire logic        hsel,        // Slave select.
	input  wire logic [31:0] haddr,       // Byte address.
	input  wire logic [1:0]  htrans,      // Transfer type.
	input  wire logic        hwrite,      // Write when high.
	input  wire logic [2:0]  hsize,       // Transfer size, word only.
	input  wire logic [31:0] hwdata,      // Write data.
	input  wire logic        hready,      // Bus ready.
	output logic             hreadyout,   // Slave ready.
	output logic             hresp,       // Always OKAY.
	output logic [31:0]      hrdata,      // Read data.
	output logic             mem_req,     // Host memory access request.
	output logic             mem_we,      // Host memory write.
	output logic [31:0]      mem_addr,    // Host memory byte address.
	output logic [31:0]      mem_wdata,   // Host memory write data.
	input  wire logic [31:0] mem_rdata,   // Host memory read data.
	input  wire logic        mem_ack,     // Access done, one cycle.
	input  wire logic        cmd_valid,   // Buffer command offered.
	output logic             cmd_ready,   // Buffer command taken.
	input  wire logic        cmd_close,   // Close open buffer as last.
	input  wire logic        cmd_small,   // Draw from small queue.
	input  wire logic [7:0]  cmd_channel, // Channel code, channel minus one.
	input  wire logic [12:0] cmd_count,   // Bytes stored in open buffer.
	output logic             grant_valid, // Command finished, one cycle.
	output logic             grant_error, // Queue was empty, one cycle.
	output logic [31:0]      grant_addr,  // New buffer address.
	output logic [12:0]      large_buffer_size, // Large buffer size.
	output logic [12:0]      small_buffer_size  // Small buffer size.
);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic [31:0] entry_addr(input logic [31:0] base, input logic [15:0] start,
			input logic [15:0] ptr);
		entry_addr = base + {13'h0000, start, 3'h0} + {13'h0000, ptr, 3'h0}; // R17
	endfunction

	function automatic logic [15:0] advance(input logic [15:0] ptr, input logic [15:0] start,
			input logic [15:0] limit);
		logic [16:0] next;
		next = {1'b0, start} + {1'b0, ptr} + 17'h00001;
		advance = (next >= {1'b0, limit}) ? 16'h0000 : ptr + 16'h0001; // R19 R20
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Register bus.

	logic [15:0]  fq_base_low_reg;
	logic [15:0]  fq_base_high_reg;
	logic [15:0]  fq_end_index_reg;
	logic [15:0]  sq_start_index_reg;
	logic [15:0]  lq_wr_ptr_reg;
	logic [15:0]  sq_wr_ptr_reg;
	logic [15:0]  lq_rd_ptr_reg;
	logic [15:0]  sq_rd_ptr_reg;
	logic [15:0]  desc_base_low_reg;
	logic [15:0]  desc_base_high_reg;
	logic         enable_reg;
	logic [3:0]   status_reg;
	logic [11:0]  dp_addr_reg;
	logic         dp_write_reg;
	logic         dp_read_reg;
	logic         rd_wait_reg;
	logic         addr_phase;
	logic         wr_en;
	logic [31:0]  rd_mux;
	logic [3:0]   status_set;
	logic         adv_large;
	logic         adv_small;
	logic [31:0]  fq_base;
	logic [31:0]  desc_base;

	assign addr_phase = hsel && hready && htrans[1];
	assign wr_en      = dp_write_reg;
	assign hresp      = 1'b0;
	assign hreadyout  = !(dp_read_reg && !rd_wait_reg);
	assign fq_base    = {fq_base_high_reg, fq_base_low_reg};
	assign desc_base  = {desc_base_high_reg, desc_base_low_reg};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_addr_reg  <= 12'h000;
			dp_write_reg <= 1'b0;
			dp_read_reg  <= 1'b0;
		end else if (hreadyout) begin
			dp_addr_reg  <= haddr[11:0];
			dp_write_reg <= addr_phase && hwrite && (haddr[31:12] == 20'h00000);
			dp_read_reg  <= addr_phase && !hwrite;
		end
	end

	// Reads take one wait state so that hrdata comes from a flip-flop.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait_reg <= 1'b0;
			hrdata      <= 32'h0000_0000;
		end else begin
			rd_wait_reg <= dp_read_reg && !rd_wait_reg;
			if (dp_read_reg && !rd_wait_reg) begin
				hrdata <= rd_mux;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (dp_addr_reg == FQ_BASE_LOW_OFS) begin
			rd_mux = {16'h0000, fq_base_low_reg};
		end else if (dp_addr_reg == FQ_BASE_HIGH_OFS) begin
			rd_mux = {16'h0000, fq_base_high_reg};
		end else if (dp_addr_reg == FQ_END_INDEX_OFS) begin
			rd_mux = {16'h0000, fq_end_index_reg};
		end else if (dp_addr_reg == SQ_START_INDEX_OFS) begin
			rd_mux = {16'h0000, sq_start_index_reg};
		end else if (dp_addr_reg == LQ_WR_PTR_OFS) begin
			rd_mux = {16'h0000, lq_wr_ptr_reg};
		end else if (dp_addr_reg == SQ_WR_PTR_OFS) begin
			rd_mux = {16'h0000, sq_wr_ptr_reg};
		end else if (dp_addr_reg == LQ_RD_PTR_OFS) begin
			rd_mux = {16'h0000, lq_rd_ptr_reg};
		end else if (dp_addr_reg == SQ_RD_PTR_OFS) begin
			rd_mux = {16'h0000, sq_rd_ptr_reg};
		end else if (dp_addr_reg == DESC_BASE_LOW_OFS) begin
			rd_mux = {16'h0000, desc_base_low_reg};
		end else if (dp_addr_reg == DESC_BASE_HIGH_OFS) begin
			rd_mux = {16'h0000, desc_base_high_reg};
		end else if (dp_addr_reg == LARGE_SIZE_OFS) begin
			rd_mux = {19'h00000, large_buffer_size};
		end else if (dp_addr_reg == SMALL_SIZE_OFS) begin
			rd_mux = {19'h00000, small_buffer_size};
		end else if (dp_addr_reg == DMA_CONTROL_OFS) begin
			rd_mux = {31'h0000_0000, enable_reg};
		end else if (dp_addr_reg == DMA_STATUS_OFS) begin
			rd_mux = {28'h000_0000, status_reg};
		end
	end

	// Host-owned configuration, written only by software.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fq_base_low_reg    <= REG16_RESET;
			fq_base_high_reg   <= REG16_RESET;
			fq_end_index_reg   <= REG16_RESET;
			sq_start_index_reg <= REG16_RESET;
			lq_wr_ptr_reg      <= REG16_RESET;
			sq_wr_ptr_reg      <= REG16_RESET;
			desc_base_low_reg  <= REG16_RESET;
			desc_base_high_reg <= REG16_RESET;
			large_buffer_size  <= SIZE_RESET;
			small_buffer_size  <= SIZE_RESET;
			enable_reg         <= 1'b0;
		end else if (wr_en) begin
			if (dp_addr_reg == FQ_BASE_LOW_OFS) begin
				fq_base_low_reg <= hwdata[15:0];
			end else if (dp_addr_reg == FQ_BASE_HIGH_OFS) begin
				fq_base_high_reg <= hwdata[15:0];
			end else if (dp_addr_reg == FQ_END_INDEX_OFS) begin
				fq_end_index_reg <= hwdata[15:0];
			end else if (dp_addr_reg == SQ_START_INDEX_OFS) begin
				sq_start_index_reg <= hwdata[15:0];
			end else if (dp_addr_reg == LQ_WR_PTR_OFS) begin
				lq_wr_ptr_reg <= hwdata[15:0];
			end else if (dp_addr_reg == SQ_WR_PTR_OFS) begin
				sq_wr_ptr_reg <= hwdata[15:0];
			end else if (dp_addr_reg == DESC_BASE_LOW_OFS) begin
				desc_base_low_reg <= hwdata[15:0];
			end else if (dp_addr_reg == DESC_BASE_HIGH_OFS) begin
				desc_base_high_reg <= hwdata[15:0];
			end else if (dp_addr_reg == LARGE_SIZE_OFS) begin
				large_buffer_size <= hwdata[12:0];
			end else if (dp_addr_reg == SMALL_SIZE_OFS) begin
				small_buffer_size <= hwdata[12:0];
			end else if (dp_addr_reg == DMA_CONTROL_OFS) begin
				enable_reg <= hwdata[CTRL_ENABLE_BIT];
			end
		end
	end

	// Read pointers: software seeds them, the engine advances them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lq_rd_ptr_reg <= REG16_RESET;
			sq_rd_ptr_reg <= REG16_RESET;
		end else begin
			if (adv_large) begin
				lq_rd_ptr_reg <= advance(lq_rd_ptr_reg, 16'h0000, sq_start_index_reg); // R14 R20
			end else if (wr_en && dp_addr_reg == LQ_RD_PTR_OFS) begin
				lq_rd_ptr_reg <= hwdata[15:0];
			end
			if (adv_small) begin
				sq_rd_ptr_reg <= advance(sq_rd_ptr_reg, sq_start_index_reg, fq_end_index_reg); // R14 R20
			end else if (wr_en && dp_addr_reg == SQ_RD_PTR_OFS) begin
				sq_rd_ptr_reg <= hwdata[15:0];
			end
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= STATUS_RESET;
		end else if (wr_en && dp_addr_reg == DMA_STATUS_OFS) begin
			status_reg <= (status_reg & ~hwdata[3:0]) | status_set;
		end else begin
			status_reg <= status_reg | status_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Free queue fetch and descriptor writer.

	rxfq_state_e         state_reg;
	logic [STAMP_W-1:0]  stamp;
	logic                op_close_reg;
	logic                op_small_reg;
	logic [7:0]          op_channel_reg;
	logic [12:0]         op_count_reg;
	logic [31:0]         new_addr_reg;
	logic [15:0]         new_index_reg;
	logic                open_valid_reg;
	logic                open_first_reg;
	logic [31:0]         open_addr_reg;
	logic [15:0]         open_index_reg;
	logic [7:0]          open_channel_reg;
	logic [2:0]          desc_status_reg;
	logic [15:0]         desc_next_reg;
	logic [31:0]         desc_addr;
	logic                sel_empty;
	logic [31:0]         sel_entry;
	logic                take;

	rxfq_timestamp u_timestamp (
		.hclk    (hclk),
		.hresetn (hresetn),
		.stamp   (stamp)
	);

	assign cmd_ready = (state_reg == ST_IDLE) && enable_reg; // R18
	assign take      = cmd_valid && cmd_ready;
	assign sel_empty = cmd_small ? (sq_rd_ptr_reg == sq_wr_ptr_reg) : (lq_rd_ptr_reg == lq_wr_ptr_reg); // R15
	assign sel_entry = cmd_small ? entry_addr(fq_base, sq_start_index_reg, sq_rd_ptr_reg)
	                             : entry_addr(fq_base, 16'h0000, lq_rd_ptr_reg); // R12 R17
	assign desc_addr = desc_base + {12'h000, open_index_reg, 4'h0}; // R11 R22 R25
	assign adv_large = (state_reg == ST_FIDX) && mem_ack && !op_small_reg; // R19
	assign adv_small = (state_reg == ST_FIDX) && mem_ack && op_small_reg; // R19
	assign mem_req   = (state_reg != ST_IDLE);

	always_comb begin
		status_set = 4'h0;
		status_set[STAT_LARGE_READ_BIT] = adv_large;
		status_set[STAT_SMALL_READ_BIT] = adv_small;
		status_set[STAT_LARGE_ERR_BIT]  = take && !cmd_close && !cmd_small && sel_empty; // R24
		status_set[STAT_SMALL_ERR_BIT]  = take && !cmd_close && cmd_small && sel_empty; // R24
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take && !cmd_close && !sel_empty) begin
						state_reg <= ST_FADDR;
					end else if (take && cmd_close && open_valid_reg) begin
						state_reg <= ST_D0;
					end
				end
				ST_FADDR: begin
					if (mem_ack) begin
						state_reg <= ST_FIDX;
					end
				end
				ST_FIDX: begin
					if (mem_ack) begin
						state_reg <= open_valid_reg ? ST_D0 : ST_IDLE;
					end
				end
				ST_D0: begin
					if (mem_ack) begin
						state_reg <= ST_D1;
					end
				end
				ST_D1: begin
					if (mem_ack) begin
						state_reg <= ST_D2;
					end
				end
				ST_D2: begin
					if (mem_ack) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Command capture and the fetched free entry.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_close_reg   <= 1'b0;
			op_small_reg   <= 1'b0;
			op_channel_reg <= 8'h00;
			op_count_reg   <= 13'h0000;
			new_addr_reg   <= 32'h0000_0000;
			new_index_reg  <= 16'h0000;
		end else begin
			if (take) begin
				op_close_reg   <= cmd_close;
				op_small_reg   <= cmd_small;
				op_channel_reg <= cmd_channel;
				op_count_reg   <= cmd_count;
			end
			if (state_reg == ST_FADDR && mem_ack) begin
				new_addr_reg <= mem_rdata; // R10
			end
			if (state_reg == ST_FIDX && mem_ack) begin
				new_index_reg <= mem_rdata[15:0]; // R10
			end
		end
	end

	// The open buffer waits for its successor, whose index it links to.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_valid_reg   <= 1'b0;
			open_first_reg   <= 1'b0;
			open_addr_reg    <= 32'h0000_0000;
			open_index_reg   <= 16'h0000;
			open_channel_reg <= 8'h00;
		end else if ((state_reg == ST_FIDX && mem_ack && !open_valid_reg) ||
				(state_reg == ST_D2 && mem_ack && !op_close_reg)) begin
			open_valid_reg   <= 1'b1;
			open_first_reg   <= !open_valid_reg || state_reg == ST_FIDX;
			open_addr_reg    <= new_addr_reg;
			open_index_reg   <= (state_reg == ST_FIDX) ? mem_rdata[15:0] : new_index_reg;
			open_channel_reg <= op_channel_reg;
		end else if (state_reg == ST_D2 && mem_ack) begin
			open_valid_reg <= 1'b0;
		end else if (state_reg == ST_D2) begin
			open_first_reg <= open_first_reg;
		end
	end

	// Status and link of the descriptor being written.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			desc_status_reg <= BUFFER_STATUS_LAST;
			desc_next_reg   <= 16'h0000;
		end else if (take && cmd_close) begin
			desc_status_reg <= BUFFER_STATUS_LAST; // R4
			desc_next_reg   <= 16'h0000;
		end else if (state_reg == ST_FIDX && mem_ack) begin
			desc_status_reg <= open_first_reg ? BUFFER_STATUS_FIRST : BUFFER_STATUS_MIDDLE; // R4
			desc_next_reg   <= mem_rdata[15:0]; // R2
		end
	end

	// Memory address and data; dword 3 is never addressed.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_we    <= 1'b0;
			mem_addr  <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
		end else if (take) begin
			mem_we    <= cmd_close;
			mem_addr  <= cmd_close ? desc_addr : sel_entry; // R17 R25
			mem_wdata <= open_addr_reg; // R1 R9
		end else if (state_reg == ST_FADDR && mem_ack) begin
			mem_addr <= mem_addr + WORD1_OFS;
		end else if (state_reg == ST_FIDX && mem_ack) begin
			mem_we    <= 1'b1;
			mem_addr  <= desc_addr;
			mem_wdata <= open_addr_reg; // R1 R9
		end else if (state_reg == ST_D0 && mem_ack) begin
			mem_addr  <= desc_addr + WORD1_OFS;
			mem_wdata <= {desc_status_reg, op_count_reg, desc_next_reg}; // R2 R3 R4 R9
		end else if (state_reg == ST_D1 && mem_ack) begin
			mem_addr  <= desc_addr + WORD2_OFS; // R7
			mem_wdata <= {stamp, open_channel_reg}; // R5 R6 R9
		end
	end

	// Answer to the command.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			grant_valid <= 1'b0;
			grant_error <= 1'b0;
			grant_addr  <= 32'h0000_0000;
		end else begin
			grant_valid <= (take && (cmd_close ? !open_valid_reg : sel_empty)) ||
				(state_reg == ST_FIDX && mem_ack && !open_valid_reg) || (state_reg == ST_D2 && mem_ack);
			grant_error <= take && !cmd_close && sel_empty; // R24
			if (state_reg == ST_FADDR && mem_ack) begin
				grant_addr <= mem_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_fetch_done;
		state_reg == ST_FIDX && mem_ack;
	endsequence

	sequence s_empty_take;
		take && !cmd_close && sel_empty;
	endsequence

	property p_no_dword3;
		@(posedge hclk) disable iff (!hresetn) mem_req && mem_we |-> mem_addr[3:2] != 2'b11;
	endproperty
	a_no_dword3: assert property (p_no_dword3) else $error("Descriptor dword 3 written."); // R7

	property p_empty_error;
		@(posedge hclk) disable iff (!hresetn)
			s_empty_take |=> grant_error && grant_valid && state_reg == ST_IDLE && $stable(lq_rd_ptr_reg)
				&& $stable(sq_rd_ptr_reg);
	endproperty
	a_empty_error: assert property (p_empty_error) else $error("Empty queue not refused."); // R24 R15

	property p_large_advance;
		@(posedge hclk) disable iff (!hresetn)
			s_fetch_done ##0 !op_small_reg ##0 ({16'h0000, lq_rd_ptr_reg} + 32'h1 < {16'h0000, sq_start_index_reg})
				|=> lq_rd_ptr_reg == $past(lq_rd_ptr_reg) + 16'h0001;
	endproperty
	a_large_advance: assert property (p_large_advance) else $error("Large pointer not advanced."); // R19

	property p_large_wrap;
		@(posedge hclk) disable iff (!hresetn)
			s_fetch_done ##0 !op_small_reg ##0 ({16'h0000, lq_rd_ptr_reg} + 32'h1 >= {16'h0000, sq_start_index_reg})
				|=> lq_rd_ptr_reg == 16'h0000;
	endproperty
	a_large_wrap: assert property (p_large_wrap) else $error("Large pointer did not wrap."); // R20

	property p_small_wrap;
		@(posedge hclk) disable iff (!hresetn)
			s_fetch_done ##0 op_small_reg ##0
				({16'h0000, sq_rd_ptr_reg} + {16'h0000, sq_start_index_reg} + 32'h1 >= {16'h0000, fq_end_index_reg})
				|=> sq_rd_ptr_reg == 16'h0000;
	endproperty
	a_small_wrap: assert property (p_small_wrap) else $error("Small pointer did not wrap."); // R20

	property p_disabled_idle;
		@(posedge hclk) disable iff (!hresetn) state_reg == ST_IDLE && !enable_reg |=> state_reg == ST_IDLE;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("Fetch started while disabled."); // R18

	property p_entry_addr;
		@(posedge hclk) disable iff (!hresetn)
			take && !cmd_close && !sel_empty && !cmd_small
				|=> mem_addr == fq_base + {13'h0000, $past(lq_rd_ptr_reg), 3'h0} && !mem_we;
	endproperty
	a_entry_addr: assert property (p_entry_addr) else $error("Wrong large entry address."); // R17

	property p_desc_word1;
		@(posedge hclk) disable iff (!hresetn)
			state_reg == ST_D1 |-> mem_addr == desc_base + {12'h000, open_index_reg, 4'h4}
				&& (mem_wdata[31:29] == BUFFER_STATUS_FIRST || mem_wdata[31:29] == BUFFER_STATUS_MIDDLE || mem_wdata[31:29] == BUFFER_STATUS_LAST);
	endproperty
	a_desc_word1: assert property (p_desc_word1) else $error("Bad descriptor dword 1."); // R4 R25

endmodule
`default_nettype wire

/* logic/rxfq_pkg.sv */
`default_nettype none
package rxfq_pkg;

	// Register byte offsets on the AHB-Lite slave.
	localparam logic [11:0] FQ_BASE_LOW_OFS     = 12'h700;
	localparam logic [11:0] FQ_BASE_HIGH_OFS    = 12'h704;
	localparam logic [11:0] FQ_END_INDEX_OFS    = 12'h708;
	localparam logic [11:0] SQ_START_INDEX_OFS  = 12'h70C;
	localparam logic [11:0] LQ_WR_PTR_OFS       = 12'h710;
	localparam logic [11:0] SQ_WR_PTR_OFS       = 12'h714;
	localparam logic [11:0] LQ_RD_PTR_OFS       = 12'h718;
	localparam logic [11:0] SQ_RD_PTR_OFS       = 12'h71C;
	localparam logic [11:0] DESC_BASE_LOW_OFS   = 12'h750;
	localparam logic [11:0] DESC_BASE_HIGH_OFS  = 12'h754;
	localparam logic [11:0] LARGE_SIZE_OFS      = 12'h790;
	localparam logic [11:0] SMALL_SIZE_OFS      = 12'h794;
	localparam logic [11:0] DMA_CONTROL_OFS     = 12'h7A0;
	localparam logic [11:0] DMA_STATUS_OFS      = 12'h7A4;

	// Field positions.
	localparam int          CTRL_ENABLE_BIT     = 0;
	localparam int          STAT_LARGE_READ_BIT = 0;
	localparam int          STAT_SMALL_READ_BIT = 1;
	localparam int          STAT_LARGE_ERR_BIT  = 2;
	localparam int          STAT_SMALL_ERR_BIT  = 3;
	localparam int          ENTRY_SHIFT         = 3;
	localparam int          DESC_SHIFT          = 4;

	// Reset values.
	localparam logic [15:0] REG16_RESET         = 16'h0000;
	localparam logic [12:0] SIZE_RESET          = 13'h0000;
	localparam logic [3:0]  STATUS_RESET        = 4'h0;

	// Buffer status codes of descriptor dword 1.
	localparam logic [2:0]  BUFFER_STATUS_FIRST          = 3'h1;
	localparam logic [2:0]  BUFFER_STATUS_MIDDLE         = 3'h2;
	localparam logic [2:0]  BUFFER_STATUS_LAST           = 3'h4;

	// Timestamp advances once per this many clock cycles.
	localparam int          STAMP_DIVIDE        = 16;
	localparam int          STAMP_W             = 24;

	// Byte offsets of descriptor and free entry words.
	localparam logic [31:0] WORD1_OFS           = 32'h0000_0004;
	localparam logic [31:0] WORD2_OFS           = 32'h0000_0008;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_FADDR = 6'b000010,
		ST_FIDX  = 6'b000100,
		ST_D0    = 6'b001000,
		ST_D1    = 6'b010000,
		ST_D2    = 6'b100000
	} rxfq_state_e;

endpackage
`default_nettype wire

/* logic/rxfq_timestamp.sv */
`timescale 1ns/1ps
`default_nettype none
module rxfq_timestamp
	import rxfq_pkg::*;
(
	input  wire logic               hclk,    // Bus clock.
	input  wire logic               hresetn, // Asynchronous reset, active low.
	output logic [STAMP_W-1:0]      stamp    // Free running arrival time.
);

	localparam logic [3:0] PRESCALE_LAST = 4'(STAMP_DIVIDE - 1);

	logic [3:0] prescale_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale_reg <= 4'h0;
		end else if (prescale_reg == PRESCALE_LAST) begin
			prescale_reg <= 4'h0;
		end else begin
			prescale_reg <= prescale_reg + 4'h1;
		end
	end

	// The count wraps naturally at the top of its width.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stamp <= '0;
		end else if (prescale_reg == PRESCALE_LAST) begin
			stamp <= stamp + 24'h000001; // R6
		end
	end

endmodule
`default_nettype wire

/* tb/rxfq_host_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module rxfq_host_mem (
	input  wire logic        hclk,      // Bus clock.
	input  wire logic        mem_req,   // Access pending.
	input  wire logic        mem_we,    // Write access.
	input  wire logic [31:0] mem_addr,  // Byte address.
	input  wire logic [31:0] mem_wdata, // Write data.
	output logic      [31:0] mem_rdata, // Read data.
	output logic             mem_ack    // Access done.
);
	logic [31:0] mem [64];
	logic [1:0]  pace_reg = 2'h0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0;
	// The answer delay varies, and read data is scrambled outside the answer.
	always @(posedge hclk) begin
		pace_reg <= pace_reg + 2'h1;
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && pace_reg != 2'h1) begin
			mem_ack <= 1'b1;
			if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
			else mem_rdata <= mem[mem_addr[7:2]];
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rxfq_pkg::*;
	localparam logic [11:0] SET_OFS [8] = '{FQ_BASE_LOW_OFS, FQ_BASE_HIGH_OFS, FQ_END_INDEX_OFS,
		SQ_START_INDEX_OFS, LQ_WR_PTR_OFS, SQ_WR_PTR_OFS, DESC_BASE_LOW_OFS, DESC_BASE_HIGH_OFS};
	localparam logic [15:0] SET_VAL [8] = '{16'h0, 16'h0, 16'h6, 16'h4, 16'h2, 16'h1, 16'h80, 16'h0};
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_req, mem_we, mem_ack;
	logic        cmd_valid, cmd_ready, cmd_close, cmd_small, grant_valid, grant_error;
	logic [1:0]  htrans;
	logic [7:0]  cmd_channel, oc, dc;
	logic [12:0] cmd_count, lbs;
	logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, grant_addr, q, lf;
	int          fails, n_checks;
	rxfq_dma i_rxfq_dma (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .cmd_valid, .cmd_ready, .cmd_close, .cmd_small, .cmd_channel, .cmd_count,
		.grant_valid, .grant_error, .grant_addr, .large_buffer_size(lbs), .small_buffer_size());
	rxfq_host_mem i_rxfq_host_mem (.hclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic cmd(input logic cl, input logic sm);
		lf = nx(lf);
		cmd_valid <= 1'b1;
		cmd_close <= cl;
		cmd_small <= sm;
		cmd_channel <= lf[7:0];
		cmd_count <= lf[20:8];
		@(posedge hclk);
		while (cmd_ready !== 1'b1) @(posedge hclk);
		cmd_valid <= 1'b0;
		do @(posedge hclk); while (grant_valid !== 1'b1);
		dc = oc;
		if (!cl && grant_error !== 1'b1) oc = cmd_channel;
	endtask
	task automatic dsc(input int i, input logic [31:0] a, input logic [2:0] s, input logic [15:0] n);
		chk("dw0", i_rxfq_host_mem.mem[32+4*i], a);
		chk("dw1", i_rxfq_host_mem.mem[33+4*i], {s, cmd_count, n});
		chk("dw2", {24'h0, i_rxfq_host_mem.mem[34+4*i][7:0]}, {24'h0, dc});
		chk("dw3", i_rxfq_host_mem.mem[35+4*i], 32'h5A5A_5A5A);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		#40000;
		fails++;
		final_report();
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, cmd_valid, cmd_close, cmd_small} = '0;
		{cmd_channel, cmd_count, fails, n_checks} = '0;
		lf = 32'h5ED4;
		for (int j = 0; j < 64; j++) i_rxfq_host_mem.mem[j] = 32'h5A5A_5A5A;
		// Entries 0 to 3 are large, entries 4 and 5 are small; upper index bits are junk.
		for (int j = 0; j < 6; j++) begin
			i_rxfq_host_mem.mem[2*j] = 32'h1000_0000 + j;
			i_rxfq_host_mem.mem[2*j+1] = {16'hFFFF, 16'(j + 1)};
		end
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, LQ_RD_PTR_OFS, 32'h0);
		chk("rptr_reset", q, {16'h0, REG16_RESET});
		bus(1'b0, 12'h7FC, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, DESC_BASE_LOW_OFS, lf);
		bus(1'b0, DESC_BASE_LOW_OFS, 32'h0);
		chk("rw", q, {16'h0, lf[15:0]});
		bus(1'b1, LARGE_SIZE_OFS, 32'hFFFF_FFFF);
		for (int j = 0; j < 8; j++) bus(1'b1, SET_OFS[j], {16'h0, SET_VAL[j]});
		chk("ready_off", {31'h0, cmd_ready}, 32'h0);
		chk("lsize", {19'h0, lbs}, 32'h1FFF);
		chk("resp", {31'h0, hresp}, 32'h0);
		bus(1'b1, DMA_CONTROL_OFS, 32'h1);
		cmd(1'b0, 1'b0);
		chk("grant0", grant_addr, 32'h1000_0000);
		bus(1'b0, LQ_RD_PTR_OFS, 32'h0);
		chk("lptr1", q, 32'h1);
		cmd(1'b0, 1'b0);
		dsc(1, 32'h1000_0000, BUFFER_STATUS_FIRST, 16'h2);
		chk("grant1", grant_addr, 32'h1000_0001);
		cmd(1'b0, 1'b0);
		chk("empty", {31'h0, grant_error}, 32'h1);
		bus(1'b0, LQ_RD_PTR_OFS, 32'h0);
		chk("lptr_held", q, 32'h2);
		cmd(1'b0, 1'b1);
		dsc(2, 32'h1000_0001, BUFFER_STATUS_MIDDLE, 16'h5);
		chk("grant_small", grant_addr, 32'h1000_0004);
		bus(1'b0, DMA_STATUS_OFS, 32'h0);
		chk("status", q, 32'h7);
		bus(1'b1, DMA_STATUS_OFS, 32'hF);
		bus(1'b0, DMA_STATUS_OFS, 32'h0);
		chk("status_clr", q, 32'h0);
		cmd(1'b1, 1'b0);
		dsc(5, 32'h1000_0004, BUFFER_STATUS_LAST, 16'h0);
		chk("stamp", {31'h0, i_rxfq_host_mem.mem[54][31:8] > i_rxfq_host_mem.mem[38][31:8]}, 32'h1);
		bus(1'b1, SQ_WR_PTR_OFS, 32'h0);
		cmd(1'b0, 1'b1);
		chk("grant_s2", grant_addr, 32'h1000_0005);
		bus(1'b0, SQ_RD_PTR_OFS, 32'h0);
		chk("sptr_wrap", q, 32'h0);
		bus(1'b1, LQ_WR_PTR_OFS, 32'h0);
		cmd(1'b0, 1'b0);
		dsc(6, 32'h1000_0005, BUFFER_STATUS_FIRST, 16'h3);
		cmd(1'b0, 1'b0);
		chk("grant3", grant_addr, 32'h1000_0003);
		bus(1'b0, LQ_RD_PTR_OFS, 32'h0);
		chk("lptr_wrap", q, 32'h0);
		bus(1'b1, SQ_START_INDEX_OFS, 32'h6);
		bus(1'b1, LQ_RD_PTR_OFS, 32'h4);
		cmd(1'b0, 1'b0);
		bus(1'b0, LQ_RD_PTR_OFS, 32'h0);
		chk("single", q, 32'h5);
		final_report();
	end
endmodule
`default_nettype wire
